// [logic/gpd_ports.sv]
/*
 * Two eight-bit general-purpose ports (C and D) behind an AXI4-Lite slave.
 * Port C pins are shared with peripheral functions whose internals live
 * elsewhere; they hand in per-pin enable, output and output enable.
 * Assumes all pin and peripheral inputs are synchronous to clk_sys_i.
 */
// How it works
// - each port is eight bidirectional pins with own direction and latch bit
// - direction one makes the pin input with driver off; resets to ones
// - direction zero drives the output latch value onto the pin
// - reading port data returns pin levels, not latch contents
// - port set/clear writes are read-modify-write into the output latch; port data writes load it whole
// - output latch is unknown after reset until software writes it
// - direction still controls drivers on analog pins; analog pins read zero
// - port D analog select forces digital reads of that pin to zero
// - analog select does not affect digital output drive
// - port D analog select bits reset to ones
// - without port D its data reads zero and writes do nothing
// - port C bits 0..2 shared with timer oscillator and capture channels
// - port C bits 3..7 shared with synchronous serial and serial port
// - second capture channel uses port C bit 1 or port B bit 3
module gpd_ports
    import gpd_pkg::*;
#(
    parameter bit PORT_D_PRESENT = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [PORT_W-1:0] port_c_pin_i,
    output logic [PORT_W-1:0] port_c_pin_o,
    output logic [PORT_W-1:0] port_c_pin_oe_o,
    input wire logic [PORT_W-1:0] port_d_pin_i,
    output logic [PORT_W-1:0] port_d_pin_o,
    output logic [PORT_W-1:0] port_d_pin_oe_o,
    input wire logic [PORT_W-1:0] c_periph_en_i,
    input wire logic [PORT_W-1:0] c_periph_out_i,
    input wire logic [PORT_W-1:0] c_periph_oe_i,
    output logic [PORT_W-1:0] c_periph_in_o,
    input wire logic second_capture_en_i,
    input wire logic second_capture_out_i,
    input wire logic second_capture_oe_i,
    output logic second_capture_in_o,
    input wire logic port_b_bit3_i,
    output logic port_b_bit3_en_o,
    output logic port_b_bit3_out_o,
    output logic port_b_bit3_oe_o
);

    // ----------------------------------------------------------------
    // decode helper
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [PORT_W-1:0] port_c_direction_reg;
    logic [PORT_W-1:0] port_d_direction_reg;
    logic [PORT_W-1:0] port_d_analog_select_reg;
    logic second_capture_pin_select_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_full_reg;
    logic [PORT_W-1:0] w_data_reg;
    logic w_strb0_reg;
    logic w_full_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    logic [PORT_W-1:0] c_rd, d_rd, c_latch, d_latch;
    logic [PORT_W-1:0] c_en, c_out, c_oe;
    logic [PORT_W-1:0] d_dir_eff, d_analog_eff;
    logic [PORT_W-1:0] rd_value;
    logic do_write, wr_ok, wr_byte, ar_take, rd_hit;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_byte = do_write && w_strb0_reg;
    assign wr_ok = hit(aw_addr_reg, OFF_C_DATA) || hit(aw_addr_reg, OFF_C_DIR) ||
                   hit(aw_addr_reg, OFF_ALT_SEL) || hit(aw_addr_reg, OFF_D_DATA) ||
                   hit(aw_addr_reg, OFF_D_DIR) || hit(aw_addr_reg, OFF_D_ANALOG) ||
                   hit(aw_addr_reg, OFF_C_SET) || hit(aw_addr_reg, OFF_C_CLR) ||
                   hit(aw_addr_reg, OFF_D_SET) || hit(aw_addr_reg, OFF_D_CLR);

    assign s_axi_awready_o = !aw_full_reg;
    assign s_axi_wready_o = !w_full_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    // write channel capture; address and data may arrive in either order
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb0_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i[PORT_W-1:0];
                w_strb0_reg <= s_axi_wstrb_i[0];
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // direction resets to inputs, analog select resets set
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            port_c_direction_reg <= RST_DIR;
            port_d_direction_reg <= RST_DIR;
            port_d_analog_select_reg <= RST_ANALOG;
            second_capture_pin_select_reg <= RST_ALT_SEL[ALT_SECOND_CAPTURE_BIT];
        end else if (wr_byte) begin
            if (hit(aw_addr_reg, OFF_C_DIR)) begin
                port_c_direction_reg <= w_data_reg;
            end
            if (hit(aw_addr_reg, OFF_ALT_SEL)) begin
                second_capture_pin_select_reg <= w_data_reg[ALT_SECOND_CAPTURE_BIT];
            end
            if (PORT_D_PRESENT && hit(aw_addr_reg, OFF_D_DIR)) begin
                port_d_direction_reg <= w_data_reg;
            end
            if (PORT_D_PRESENT && hit(aw_addr_reg, OFF_D_ANALOG)) begin
                port_d_analog_select_reg <= w_data_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // peripheral routing on port C
    // ----------------------------------------------------------------
    // bit0 timer osc/clock, bit1 osc in + second capture, bit2 first capture
    // bits 3..5 synchronous serial, bits 6..7 serial port, via c_periph_*
    // second capture lands on port C bit 1 only while the select is clear
    assign c_en = c_periph_en_i |
        (PORT_W'(second_capture_en_i && !second_capture_pin_select_reg) << C_SECOND_CAPTURE_PIN);
    assign c_out = c_periph_out_i |
        (PORT_W'(second_capture_out_i && !second_capture_pin_select_reg) << C_SECOND_CAPTURE_PIN);
    assign c_oe = c_periph_oe_i |
        (PORT_W'(second_capture_oe_i && !second_capture_pin_select_reg) << C_SECOND_CAPTURE_PIN);
    // alternate location on port B bit 3
    assign port_b_bit3_en_o = second_capture_en_i && second_capture_pin_select_reg;
    assign port_b_bit3_out_o = second_capture_out_i && second_capture_pin_select_reg;
    assign port_b_bit3_oe_o = second_capture_oe_i && second_capture_pin_select_reg;
    assign second_capture_in_o = second_capture_pin_select_reg ? port_b_bit3_i :
                                 port_c_pin_i[C_SECOND_CAPTURE_PIN];
    // peripherals see raw pin levels
    assign c_periph_in_o = port_c_pin_i;

    // missing port D: drivers held off, analog forced so reads give zero
    assign d_dir_eff = PORT_D_PRESENT ? port_d_direction_reg : RST_DIR;
    assign d_analog_eff = PORT_D_PRESENT ? port_d_analog_select_reg : RST_ANALOG;

    // ----------------------------------------------------------------
    // port slices
    // ----------------------------------------------------------------
    // one byte per port for direction and latch
    gpd_port #(.WIDTH(PORT_W)) u_port_c (
        .clk_sys_i(clk_sys_i),
        .dir_i(port_c_direction_reg),
        .analog_i('0),
        .periph_en_i(c_en),
        .periph_out_i(c_out),
        .periph_oe_i(c_oe),
        .pin_i(port_c_pin_i),
        .wr_full_i(wr_byte && hit(aw_addr_reg, OFF_C_DATA)),
        .wr_set_i(wr_byte && hit(aw_addr_reg, OFF_C_SET)),
        .wr_clr_i(wr_byte && hit(aw_addr_reg, OFF_C_CLR)),
        .wdata_i(w_data_reg),
        .rd_o(c_rd),
        .latch_o(c_latch),
        .pin_o(port_c_pin_o),
        .pin_oe_o(port_c_pin_oe_o)
    );

    // analog select masks reads, drive unaffected
    gpd_port #(.WIDTH(PORT_W)) u_port_d (
        .clk_sys_i(clk_sys_i),
        .dir_i(d_dir_eff),
        .analog_i(d_analog_eff),
        .periph_en_i('0),
        .periph_out_i('0),
        .periph_oe_i('0),
        .pin_i(port_d_pin_i),
        .wr_full_i(PORT_D_PRESENT && wr_byte && hit(aw_addr_reg, OFF_D_DATA)),
        .wr_set_i(PORT_D_PRESENT && wr_byte && hit(aw_addr_reg, OFF_D_SET)),
        .wr_clr_i(PORT_D_PRESENT && wr_byte && hit(aw_addr_reg, OFF_D_CLR)),
        .wdata_i(w_data_reg),
        .rd_o(d_rd),
        .latch_o(d_latch),
        .pin_o(port_d_pin_o),
        .pin_oe_o(port_d_pin_oe_o)
    );

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign ar_take = s_axi_arvalid_i && !rvalid_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;

    // data offsets read pins; set/clear aliases read the same
    assign rd_value =
        (hit(s_axi_araddr_i, OFF_C_DATA) || hit(s_axi_araddr_i, OFF_C_SET) ||
         hit(s_axi_araddr_i, OFF_C_CLR)) ? c_rd :
        hit(s_axi_araddr_i, OFF_C_DIR) ? port_c_direction_reg :
        hit(s_axi_araddr_i, OFF_ALT_SEL) ?
            (PORT_W'(second_capture_pin_select_reg) << ALT_SECOND_CAPTURE_BIT) :
        (hit(s_axi_araddr_i, OFF_D_DATA) || hit(s_axi_araddr_i, OFF_D_SET) ||
         hit(s_axi_araddr_i, OFF_D_CLR)) ? d_rd :
        (hit(s_axi_araddr_i, OFF_D_DIR) && PORT_D_PRESENT) ? port_d_direction_reg :
        (hit(s_axi_araddr_i, OFF_D_ANALOG) && PORT_D_PRESENT) ? port_d_analog_select_reg :
        '0;
    assign rd_hit = hit(s_axi_araddr_i, OFF_C_DATA) || hit(s_axi_araddr_i, OFF_C_DIR) ||
                    hit(s_axi_araddr_i, OFF_ALT_SEL) || hit(s_axi_araddr_i, OFF_D_DATA) ||
                    hit(s_axi_araddr_i, OFF_D_DIR) || hit(s_axi_araddr_i, OFF_D_ANALOG) ||
                    hit(s_axi_araddr_i, OFF_C_SET) || hit(s_axi_araddr_i, OFF_C_CLR) ||
                    hit(s_axi_araddr_i, OFF_D_SET) || hit(s_axi_araddr_i, OFF_D_CLR);

    // read data is registered so the pin sample is the one at the address edge
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= {24'h000000, rd_value};
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_c_set_write;
        wr_byte && hit(aw_addr_reg, OFF_C_SET);
    endsequence

    sequence s_d_full_write;
        PORT_D_PRESENT && wr_byte && hit(aw_addr_reg, OFF_D_DATA);
    endsequence

    property p_dir_reset;
        @(posedge clk_sys_i) disable iff (rst_i)
        $fell(rst_i) |-> (port_c_direction_reg == 8'hff) && (port_d_pin_oe_o == 8'h00) &&
                         (d_analog_eff == 8'hff);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction or analog reset wrong");

    property p_input_hiz;
        @(posedge clk_sys_i) disable iff (rst_i)
        ((port_c_pin_oe_o & port_c_direction_reg & ~c_en) == 8'h00) &&
        ((port_d_pin_oe_o & d_dir_eff) == 8'h00);
    endproperty
    a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

    // per pin, so any mix of inputs and outputs exercises it
    property p_drive_latch;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_d_full_write |=>
            (d_latch == $past(w_data_reg)) && (port_d_pin_o == (d_latch & ~d_dir_eff));
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("output not latch value");

    property p_read_pins;
        @(posedge clk_sys_i) disable iff (rst_i)
        ar_take && hit(s_axi_araddr_i, OFF_C_DATA) |=>
            s_axi_rvalid_o && (s_axi_rdata_o == {24'h000000, $past(port_c_pin_i)});
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("port C read not pin level");

    property p_rmw_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_c_set_write |=> c_latch == ($past(port_c_pin_i) | $past(w_data_reg));
    endproperty
    a_rmw_set: assert property (p_rmw_set) else $error("set write merge wrong");

    property p_analog_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        ar_take && hit(s_axi_araddr_i, OFF_D_DATA) |=>
            (s_axi_rdata_o[PORT_W-1:0] & $past(d_analog_eff)) == 8'h00;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read non-zero");

    property p_analog_drives;
        @(posedge clk_sys_i) disable iff (rst_i)
        port_d_pin_oe_o == ~d_dir_eff;
    endproperty
    a_analog_drives: assert property (p_analog_drives) else $error("analog select hit drive");

    property p_absent_d;
        @(posedge clk_sys_i) disable iff (rst_i)
        !PORT_D_PRESENT && ar_take && hit(s_axi_araddr_i, OFF_D_DATA) |=> s_axi_rdata_o == 32'h0;
    endproperty
    a_absent_d: assert property (p_absent_d) else $error("absent port D read non-zero");

    property p_second_route;
        @(posedge clk_sys_i) disable iff (rst_i)
        second_capture_en_i && second_capture_oe_i |->
            (second_capture_pin_select_reg ? port_b_bit3_oe_o :
             port_c_pin_oe_o[C_SECOND_CAPTURE_PIN]);
    endproperty
    a_second_route: assert property (p_second_route) else $error("second capture misrouted");

    property p_write_answer;
        @(posedge clk_sys_i) disable iff (rst_i)
        aw_full_reg && w_full_reg && !bvalid_reg |=> s_axi_bvalid_o;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response late");

endmodule

// [logic/gpd_pkg.sv]
/*
 * Shared constants for the two eight-bit general-purpose I/O ports:
 * register byte offsets, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
package gpd_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 12;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_C_DATA = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_C_DIR = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_ALT_SEL = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_D_DATA = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_D_DIR = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_D_ANALOG = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_C_SET = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_C_CLR = 12'h01c;
    localparam logic [ADDR_W-1:0] OFF_D_SET = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_D_CLR = 12'h024;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_DIR = 8'hff;
    localparam logic [PORT_W-1:0] RST_ANALOG = 8'hff;
    localparam logic [PORT_W-1:0] RST_ALT_SEL = 8'h00;
    localparam int ALT_SECOND_CAPTURE_BIT = 0;
    localparam int C_SECOND_CAPTURE_PIN = 1;

    // ----------------------------------------------------------------
    // bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [logic/gpd_port.sv]
/*
 * One eight-bit port slice: output latch with read-modify-write update,
 * driver enable from the direction bits or a peripheral override, and the
 * digital read path with analog masking.
 * Assumes pin levels arrive synchronous to clk_sys_i.
 */
module gpd_port #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic [WIDTH-1:0] dir_i,
    input wire logic [WIDTH-1:0] analog_i,
    input wire logic [WIDTH-1:0] periph_en_i,
    input wire logic [WIDTH-1:0] periph_out_i,
    input wire logic [WIDTH-1:0] periph_oe_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic wr_full_i,
    input wire logic wr_set_i,
    input wire logic wr_clr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rd_o,
    output logic [WIDTH-1:0] latch_o,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o
);

    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    logic [WIDTH-1:0] drive_value;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // pin levels read
    assign rd_o = pin_i & ~analog_i;

    // ----------------------------------------------------------------
    // output latch
    // ----------------------------------------------------------------
    // read-modify-write merge: set/clear forms load untouched bits from the digital read, zero on analog pins
    assign latch_next = wr_full_i ? wdata_i :
                        wr_set_i ? (rd_o | wdata_i) :
                        wr_clr_i ? (rd_o & ~wdata_i) : latch_reg;

    // latch unreset: content stays unknown until software writes it
    always_ff @(posedge clk_sys_i) begin
        latch_reg <= latch_next;
    end

    assign latch_o = latch_reg;

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    // peripheral override of value and enable
    assign drive_value = (periph_en_i & periph_out_i) | (~periph_en_i & latch_reg);
    // input tri-states, output drives, analog ignored here
    assign pin_oe_o = (periph_en_i & periph_oe_i) | (~periph_en_i & ~dir_i);
    // zero while tri-stated so the unknown latch does not leak out of input pins
    assign pin_o = drive_value & pin_oe_o;

endmodule

// [verif/gpd_board.sv]
/*
 * Board side of one eight-bit port: resolves each pin level.
 * Assumes the bench supplies the level of outside sources in ext_i.
 */
module gpd_board (
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] lvl_o
);
    timeunit 1ns;
    timeprecision 100ps;
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// [verif/tb.sv]
/*
 * Self-checking bench for the two ports behind the AXI4-Lite slave.
 * Assumes the register map and timing of the gpd_pkg constants.
 */
module tb import gpd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 0, rst_i = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, sc_in, pb_en, pb_out, pb_oe;
    logic [1:0] bresp, rresp, br;
    logic [7:0] c_in, c_out, c_oe, d_in, d_out, d_oe, cpi, lc, dc, v, e;
    logic [7:0] ext_c = 0, ext_d = 0, pen = 0, pout = 0, poe = 0;
    logic sc_en = 0, pb = 0;
    logic [3:0] ws = 4'h1;
    int error_cnt = 0, compares = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    gpd_ports DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .port_c_pin_i(c_in), .port_c_pin_o(c_out), .port_c_pin_oe_o(c_oe),
        .port_d_pin_i(d_in), .port_d_pin_o(d_out), .port_d_pin_oe_o(d_oe),
        .c_periph_en_i(pen), .c_periph_out_i(pout), .c_periph_oe_i(poe),
        .c_periph_in_o(cpi), .second_capture_en_i(sc_en), .second_capture_out_i(sc_en),
        .second_capture_oe_i(sc_en), .second_capture_in_o(sc_in), .port_b_bit3_i(pb),
        .port_b_bit3_en_o(pb_en), .port_b_bit3_out_o(pb_out), .port_b_bit3_oe_o(pb_oe));
    gpd_board brd_c (.drv_i(c_out), .oe_i(c_oe), .ext_i(ext_c), .lvl_o(c_in));
    gpd_board brd_d (.drv_i(d_out), .oe_i(d_oe), .ext_i(ext_d), .lvl_o(d_in));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // model of the pin level seen by a read
    function logic [7:0] pv(input logic [7:0] l, input logic [7:0] d, input logic [7:0] x);
        return (~d & l) | (d & x);
    endfunction
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys_i);
            if (awvalid && awready) aw = 1;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) w = 1;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        do @(posedge clk_sys_i); while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
        #1;
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] x, input logic [1:0] rs);
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, x});
        chk(rresp, rs);
    endtask
    task test_done;
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // watchdog: whole run is a few hundred cycles, limit is 40000 cycles
    initial begin
        #200000;
        error_cnt++;
        $display("BAD %0t timeout", $time);
        test_done;
    end
    initial begin
        v = $urandom(80);
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(OFF_C_DIR, 8'hff, RESP_OKAY);
        rdc(OFF_D_ANALOG, 8'hff, RESP_OKAY);
        rdc(OFF_ALT_SEL, 8'h00, RESP_OKAY);
        chk({c_oe, d_oe}, 16'h0);
        chk({c_out, d_out}, 16'h0);
        rdc(12'h100, 8'h00, RESP_SLVERR);
        wr(12'h104, 8'h5a);
        chk(br, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            dc = $urandom;
            lc = $urandom;
            v = $urandom;
            @(posedge clk_sys_i);
            ext_c <= $urandom;
            wr(OFF_C_DIR, dc);
            wr(OFF_C_DATA, lc);
            chk({c_oe, c_out}, {~dc, ~dc & lc});
            rdc(OFF_C_DATA, pv(lc, dc, ext_c), RESP_OKAY);
            wr(OFF_C_SET, v);
            lc = pv(lc, dc, ext_c) | v;
            wr(OFF_C_CLR, v >> 1);
            lc = pv(lc, dc, ext_c) & ~(v >> 1);
            chk(c_out, ~dc & lc);
        end
        // byte lane 0 off: the write is answered but leaves the register alone
        @(posedge clk_sys_i);
        ws <= 4'h0;
        wr(OFF_C_DIR, ~dc);
        ws <= 4'h1;
        chk(br, RESP_OKAY);
        rdc(OFF_C_DIR, dc, RESP_OKAY);
        // peripheral takeover of port C pins
        @(posedge clk_sys_i);
        pen <= $urandom;
        pout <= $urandom;
        poe <= $urandom;
        @(posedge clk_sys_i);
        #1;
        e = (pen & poe) | (~pen & ~dc);
        v = e & ((pen & pout) | (~pen & lc));
        chk({c_oe, c_out}, {e, v});
        chk(cpi, v | (~e & ext_c));
        for (int b = 0; b < 2; b++) begin
            wr(OFF_ALT_SEL, 8'(b));
            @(posedge clk_sys_i);
            pb <= $urandom;
            sc_en <= 1'b1;
            @(posedge clk_sys_i);
            #1;
            chk(sc_in, b ? pb : 1'b1);
            chk({pb_en, pb_out, pb_oe}, {3{b[0]}});
        end
        @(posedge clk_sys_i);
        ext_d <= $urandom;
        sc_en <= 1'b0;
        rdc(OFF_D_DATA, 8'h00, RESP_OKAY);
        wr(OFF_D_DIR, 8'h0f);
        wr(OFF_D_DATA, 8'ha5);
        chk({d_oe, d_out}, 16'hf0a0);
        wr(OFF_D_SET, 8'h03);
        chk(d_out, 8'h00);
        wr(OFF_D_ANALOG, 8'h00);
        rdc(OFF_D_DATA, pv(8'h03, 8'h0f, ext_d), RESP_OKAY);
        test_done;
    end
endmodule
